/* bench/i2c_master_model.sv */
// I2C bus master model for the clock-stretch bench
`timescale 1ns/100ps

// ****************************************
// Master model
// ****************************************
module i2c_master_model (
  input wire logic sclOe, // Slave holds SCL low
  input wire logic sdaOe, // Slave pulls SDA low
  output logic sclLine, // Resolved SCL wire
  output logic sdaLine // Resolved SDA wire
);
  logic sclDrv = 1'b1;
  logic sdaDrv = 1'b1;

  // Both wires have pull-ups, so a released wire reads high
  assign sclLine = sclDrv & ~sclOe;
  assign sdaLine = sdaDrv & ~sdaOe;

  // Clock sync: watch the wire itself, the slave may be stretching
  task automatic waitHigh();
    for (int g = 0; g < 2000 && sclLine !== 1'b1; g++) #10;
  endtask

  // One 80 ns SCL pulse; the data wire is sampled mid-high
  task automatic pulse(output logic smp);
    #20 sclDrv = 1'b1;
    waitHigh();
    #20 smp = sdaLine;
    #20 sclDrv = 1'b0;
    #20;
  endtask

  // Also serves as repeated start when entered with SCL low
  task automatic start();
    sdaDrv = 1'b1;
    #20 sclDrv = 1'b1;
    waitHigh();
    #40 sdaDrv = 1'b0;
    #40 sclDrv = 1'b0;
    #20;
  endtask

  task automatic stop();
    sdaDrv = 1'b0;
    #20 sclDrv = 1'b1;
    waitHigh();
    #40 sdaDrv = 1'b1;
    #40;
  endtask

  // Extra low time before a byte, so a stretch is never raced by our own release
  task automatic writeByte(input logic [7:0] b, output logic ack);
    logic s;
    #60;
    for (int i = 7; i >= 0; i--) begin
      sdaDrv = b[i];
      pulse(s);
    end
    sdaDrv = 1'b1;
    pulse(s);
    ack = ~s;
  endtask

  task automatic readByte(input logic nack, output logic [7:0] b);
    logic s;
    #60;
    sdaDrv = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      pulse(s);
      b[i] = s;
    end
    sdaDrv = nack;
    pulse(s);
    sdaDrv = 1'b1;
  endtask
endmodule

/* bench/i2c_slave_clock_stretch_tb.sv */
// Self-checking testbench for the I2C slave clock-stretch block
`timescale 1ns/100ps

module i2c_slave_clock_stretch_tb;
  logic mclk, resetn, tenBitMode, stretchEnable, addrWr, ckpSet, txWr, rdReady, se, early, ack;
  logic sdaOe, sclOe, sclLine, sdaLine, rdValid, clockRelease, updateAddress, bufferFull;
  logic [9:0] addrWrData, own;
  logic [7:0] txWrData, rdData, b, got, exp8;
  logic [7:0] rxExp[$];
  int n_mismatch = 0;
  int checked = 0;

  i2c_slave_clock_stretch #(.DEPTH(stretch_pkg::FIFO_DEPTH)) u_i2c_slave_clock_stretch (
    .mclk(mclk), .resetn(resetn), .sclClk(sclLine), .sdaIn(sdaLine), .sdaOut(), .sdaOe(sdaOe),
    .sclOut(), .sclOe(sclOe), .tenBitMode(tenBitMode), .stretchEnable(stretchEnable), .addrWr(addrWr),
    .addrWrData(addrWrData), .ckpSet(ckpSet), .txWr(txWr), .txWrData(txWrData), .rdData(rdData),
    .rdValid(rdValid), .rdReady(rdReady), .clockRelease(clockRelease), .updateAddress(updateAddress),
    .bufferFull(bufferFull));
  i2c_master_model u_i2c_master_model (.sclOe(sclOe), .sdaOe(sdaOe), .sclLine(sclLine), .sdaLine(sdaLine));

  // ****************************************
  // Clock, checks and helpers
  // ****************************************
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic chk1(input logic g, input logic e);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, g, e);
    end
  endtask

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, g, e);
    end
  endtask

  // Every byte software pops must be the next one the master sent
  always @(posedge mclk) begin
    if (rdValid === 1'b1 && rdReady === 1'b1) begin
      exp8 = (rxExp.size() > 0) ? rxExp.pop_front() : ~rdData;
      chk8(rdData, exp8);
    end
  end

  function automatic logic [7:0] hdr(input logic [9:0] a, input logic rd);
    return {stretch_pkg::TEN_HDR, a[9:8], rd};
  endfunction

  // Software pulses last one cycle; their effect is looked at just after the taking edge
  task automatic pulseSw(input logic c, input logic a, input logic t, input logic [9:0] d);
    @(posedge mclk);
    ckpSet <= c;
    addrWr <= a;
    txWr <= t;
    addrWrData <= d;
    txWrData <= d[7:0];
    @(posedge mclk);
    ckpSet <= 1'b0;
    addrWr <= 1'b0;
    txWr <= 1'b0;
    #1;
  endtask

  // Stretch decision lands 2-3 cycles after the ninth fall; wait past it
  task automatic settle();
    repeat (8) @(posedge mclk);
    #1;
  endtask

  task automatic expState(input logic oe, input logic clock_release);
    chk1(sclOe, oe);
    chk1(clockRelease, clock_release);
  endtask

  task automatic drain();
    @(posedge mclk) rdReady <= 1'b1;
    repeat (6) @(posedge mclk);
    rdReady <= 1'b0;
  endtask

  task automatic txByte(input logic nack);
    b = 8'($urandom);
    pulseSw(1'b0, 1'b0, 1'b1, {2'h0, b});
    pulseSw(1'b1, 1'b0, 1'b0, 10'h000);
    expState(1'b0, 1'b1);
    u_i2c_master_model.readByte(nack, got);
    chk8(got, b);
    settle();
    expState(1'b1, 1'b0);
  endtask

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Watchdog: the whole sequence needs well under a tenth of this
  initial begin
    #800000;
    n_mismatch++;
    report_and_stop();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {resetn, tenBitMode, stretchEnable, addrWr, ckpSet, txWr, rdReady} = '0;
    addrWrData = 10'h000;
    txWrData = 8'h00;
    own = 10'($urandom(93)) & 10'h3BF;
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    #1;
    expState(1'b0, stretch_pkg::CKP_RST);
    repeat (5) @(posedge mclk);
    pulseSw(1'b0, 1'b1, 1'b0, own);
    // 7-bit receive: stretch only when enabled and the byte is still unread
    u_i2c_master_model.start();
    u_i2c_master_model.writeByte({own[6:0], 1'b0}, ack);
    chk1(ack, 1'b1);
    settle();
    expState(1'b0, 1'b1);
    for (int i = 0; i < 6; i++) begin
      se = (i inside {0, 1, 5}) | ((i inside {3, 4}) & 1'($urandom));
      early = (i == 1) | ((i inside {3, 4}) & 1'($urandom));
      b = 8'($urandom);
      rxExp.push_back(b);
      @(posedge mclk);
      stretchEnable <= se;
      rdReady <= early;
      u_i2c_master_model.writeByte(b, ack);
      settle();
      expState(se & ~early, ~(se & ~early));
      if (se & ~early) begin
        pulseSw(1'b1, 1'b0, 1'b0, own);
        expState(1'b0, 1'b1);
      end
      if (i < 5) begin
        drain();
      end
    end
    u_i2c_master_model.stop();
    // 7-bit transmit: preloaded byte avoids the address stretch
    @(posedge mclk) stretchEnable <= 1'b0;
    b = 8'($urandom);
    pulseSw(1'b0, 1'b0, 1'b1, {2'h0, b});
    u_i2c_master_model.start();
    u_i2c_master_model.writeByte({own[6:0], 1'b1}, ack);
    settle();
    expState(1'b0, 1'b1);
    u_i2c_master_model.readByte(1'b0, got);
    chk8(got, b);
    settle();
    expState(1'b1, 1'b0);
    txByte(1'b1);
    pulseSw(1'b1, 1'b0, 1'b0, own);
    u_i2c_master_model.stop();
    // 10-bit: address stretches leave clock_release alone, an unread byte notwithstanding
    @(posedge mclk);
    tenBitMode <= 1'b1;
    stretchEnable <= 1'b1;
    u_i2c_master_model.start();
    u_i2c_master_model.writeByte(hdr(own, 1'b0), ack);
    settle();
    expState(1'b1, 1'b1);
    chk1(updateAddress, 1'b1);
    chk1(bufferFull, 1'b1);
    pulseSw(1'b0, 1'b1, 1'b0, own);
    expState(1'b0, 1'b1);
    u_i2c_master_model.writeByte(own[7:0], ack);
    settle();
    expState(1'b1, 1'b1);
    chk1(updateAddress, 1'b1);
    pulseSw(1'b0, 1'b1, 1'b0, own);
    expState(1'b0, 1'b1);
    drain();
    b = 8'($urandom);
    rxExp.push_back(b);
    u_i2c_master_model.writeByte(b, ack);
    settle();
    expState(1'b1, 1'b0);
    pulseSw(1'b1, 1'b0, 1'b0, own);
    drain();
    u_i2c_master_model.start();
    u_i2c_master_model.writeByte(hdr(own, 1'b1), ack);
    chk1(ack, 1'b1);
    settle();
    expState(1'b1, 1'b0);
    chk1(updateAddress, 1'b0);
    txByte(1'b1);
    pulseSw(1'b1, 1'b0, 1'b0, own);
    u_i2c_master_model.stop();
    chk8(8'(rxExp.size()), 8'h00);
    report_and_stop();
  end
endmodule

/* rtl/i2c_slave_clock_stretch.sv */
// I2C slave clock-stretch control with its receive FIFO
`timescale 1ns/100ps

// ****************************************
// Receive FIFO
// ****************************************
module stretch_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic mclk, // System clock
  input wire logic resetn, // Async reset, active low
  input wire logic inValid, // Write request
  output logic inReady, // Space available
  input wire logic [WIDTH-1:0] inData, // Write word
  output logic outValid, // Word available
  input wire logic outReady, // Reader takes word
  output logic [WIDTH-1:0] outData // Head word
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // Pointer arithmetic below relies on a power-of-two depth
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_badDepth
    $error("stretch_fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrPtr_ff;
  logic [AW:0] rdPtr_ff;
  wire logic push;
  wire logic pop;
  wire logic full;

  // Full when the wrap bits differ and the indices meet
  assign full = (wrPtr_ff[AW] != rdPtr_ff[AW]) && (wrPtr_ff[AW-1:0] == rdPtr_ff[AW-1:0]);
  assign inReady = ~full;
  assign outValid = wrPtr_ff != rdPtr_ff;
  assign push = inValid & ~full;
  assign pop = outValid & outReady;
  assign outData = mem[rdPtr_ff[AW-1:0]];

  // Storage carries no reset; only the pointers define state
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wrPtr_ff[AW-1:0]] <= inData;
    end
  end

  // Pointers
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
    end else begin
      wrPtr_ff <= wrPtr_ff + (AW+1)'(push);
      rdPtr_ff <= rdPtr_ff + (AW+1)'(pop);
    end
  end
endmodule

// ****************************************
// Clock-stretch top
// ****************************************
module i2c_slave_clock_stretch #(
  parameter int DEPTH = stretch_pkg::FIFO_DEPTH
) (
  input wire logic mclk, // System clock, 100 MHz
  input wire logic resetn, // Async reset, active low
  input wire logic sclClk, // SCL pin, link clock
  input wire logic sdaIn, // SDA pin level
  output logic sdaOut, // SDA drive value, always low
  output logic sdaOe, // SDA pulled low while high
  output logic sclOut, // SCL drive value, always low
  output logic sclOe, // SCL held low while high
  input wire logic tenBitMode, // 10-bit addressing
  input wire logic stretchEnable, // stretch_enable
  input wire logic addrWr, // slave_address_reg write strobe
  input wire logic [9:0] addrWrData, // slave_address_reg value
  input wire logic ckpSet, // Sets clock_release
  input wire logic txWr, // serial_data_buffer load for transmit
  input wire logic [7:0] txWrData, // Transmit byte
  output logic [7:0] rdData, // Received byte
  output logic rdValid, // Received byte available
  input wire logic rdReady, // Software reads byte
  output logic clockRelease, // clock_release state
  output logic updateAddress, // update_address_flag
  output logic bufferFull // buffer_full
);
  if (DEPTH < 2) begin : g_badDepth
    $error("receive FIFO needs at least two entries");
  end

  // ****************************************
  // System-domain registers
  // ****************************************
  logic [9:0] slaveAddr_ff;
  logic [7:0] txHold_ff;
  logic txLoaded_ff;
  logic clockRelease_ff;
  logic updAddr_ff;
  logic uaStretch_ff;
  logic rxPend_ff;
  logic fullHold_ff;
  logic [7:0] rxPendData_ff;
  logic sclS1_ff, sclS2_ff, sclS3_ff;
  logic sdaS1_ff, sdaS2_ff, sdaS3_ff;
  logic byteS1_ff, byteS2_ff, byteS3_ff;
  logic nineS1_ff, nineS2_ff, nineS3_ff;
  logic linkHold_ff;
  logic idle_ff;
  stretch_pkg::linkWord_s word_ff;

  // ****************************************
  // Link-domain registers
  // ****************************************
  logic [3:0] bitCnt_ff;
  logic [7:0] shift_ff;
  logic [1:0] byteIdx_ff;
  logic addressed_ff;
  logic readMode_ff;
  logic tenPend_ff;
  logic ackNext_ff;
  logic txActive_ff;
  logic tenMatch_ff;
  logic byteTgl_ff;
  stretch_pkg::linkWord_s linkWord_ff;
  logic nineTgl_ff;
  logic sdaAck_ff;
  logic txPhase_ff;
  logic [2:0] txBit_ff;

  // ****************************************
  // Start and stop detection, link reset
  // ****************************************
  wire logic startEv;
  wire logic stopEv;
  wire logic linkRstN;
  assign startEv = sclS2_ff & sclS3_ff & sdaS3_ff & ~sdaS2_ff;
  assign stopEv = sclS2_ff & sclS3_ff & ~sdaS3_ff & sdaS2_ff;
  // Link logic is held in reset between frames and across each start
  assign linkRstN = resetn & ~linkHold_ff;

  // Pin synchronisers; only the second and third stages feed logic
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      {sclS1_ff, sclS2_ff, sclS3_ff} <= 3'h7;
      {sdaS1_ff, sdaS2_ff, sdaS3_ff} <= 3'h7;
    end else begin
      {sclS1_ff, sclS2_ff, sclS3_ff} <= {sclClk, sclS1_ff, sclS2_ff};
      {sdaS1_ff, sdaS2_ff, sdaS3_ff} <= {sdaIn, sdaS1_ff, sdaS2_ff};
    end
  end

  // Frame tracking: a start opens, a stop closes
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      idle_ff <= 1'b1;
      linkHold_ff <= 1'b1;
    end else begin
      idle_ff <= stopEv | (idle_ff & ~startEv);
      linkHold_ff <= startEv | stopEv | (linkHold_ff & (sclS2_ff | idle_ff));
    end
  end

  // ****************************************
  // Link domain: bit shifting on SCL rising
  // ****************************************
  wire logic [7:0] rxByte;
  wire logic hdrMatch;
  wire logic sevenMatch;
  wire logic lowMatch;
  wire logic firstByte;
  wire logic lastBit;
  wire logic ackSlot;
  wire logic ackWrHdr;
  wire logic ackRdHdr;
  wire logic ackLow;
  wire logic ackData;
  wire logic ackThis;
  assign rxByte = {shift_ff[6:0], sdaIn};
  assign firstByte = byteIdx_ff == 2'h0;
  assign lastBit = bitCnt_ff == stretch_pkg::LAST_DATA_BIT;
  assign ackSlot = bitCnt_ff == stretch_pkg::ACK_SLOT;
  assign hdrMatch = (rxByte[7:3] == stretch_pkg::TEN_HDR) && (rxByte[2:1] == slaveAddr_ff[9:8]);
  assign sevenMatch = rxByte[7:1] == slaveAddr_ff[6:0];
  assign lowMatch = rxByte == slaveAddr_ff[7:0];
  assign ackWrHdr = firstByte & tenBitMode & hdrMatch & ~rxByte[0];
  // A read header is only honoured after a full 10-bit match
  assign ackRdHdr = firstByte & tenBitMode & hdrMatch & rxByte[0] & tenMatch_ff;
  assign ackLow = ~firstByte & tenPend_ff & lowMatch;
  assign ackData = ~firstByte & addressed_ff;
  assign ackThis = ackWrHdr | ackRdHdr | ackLow | ackData | (firstByte & ~tenBitMode & sevenMatch);

  // Bit counter, address decode and transmit tracking
  always_ff @(posedge sclClk or negedge linkRstN) begin
    if (!linkRstN) begin
      bitCnt_ff <= '0;
      shift_ff <= '0;
      byteIdx_ff <= '0;
      addressed_ff <= 1'b0;
      readMode_ff <= 1'b0;
      tenPend_ff <= 1'b0;
      ackNext_ff <= 1'b0;
      txActive_ff <= 1'b0;
    end else begin
      bitCnt_ff <= ackSlot ? 4'h0 : bitCnt_ff + 4'h1;
      if (!ackSlot) begin
        shift_ff <= rxByte;
      end
      if (lastBit) begin
        ackNext_ff <= ackThis & ~readMode_ff;
        if (firstByte) begin
          addressed_ff <= ackThis & (~tenBitMode | rxByte[0]);
          readMode_ff <= ackThis & rxByte[0];
          tenPend_ff <= ackWrHdr;
        end else if (tenPend_ff) begin
          addressed_ff <= ackLow;
          tenPend_ff <= 1'b0;
        end
      end
      if (ackSlot) begin
        byteIdx_ff <= (byteIdx_ff == stretch_pkg::IDX_MAX) ? byteIdx_ff : byteIdx_ff + 2'h1;
        // Master acknowledge keeps transmit going, a nack ends it
        txActive_ff <= readMode_ff & (~txActive_ff | ~sdaIn);
      end
    end
  end

  // Byte report and 10-bit match survive repeated starts
  always_ff @(posedge sclClk or negedge resetn) begin
    if (!resetn) begin
      byteTgl_ff <= 1'b0;
      linkWord_ff <= stretch_pkg::WORD_RST;
      tenMatch_ff <= 1'b0;
    end else if (lastBit && linkRstN) begin
      byteTgl_ff <= ~byteTgl_ff;
      linkWord_ff.data <= rxByte;
      linkWord_ff.isData <= ~firstByte & ~tenPend_ff & addressed_ff;
      linkWord_ff.setUa <= ackWrHdr | ackLow;
      linkWord_ff.isRead <= readMode_ff | ackRdHdr | (ackThis & firstByte & rxByte[0]);
      linkWord_ff.acked <= ackThis;
      if (ackLow) begin
        tenMatch_ff <= 1'b1;
      end else if (firstByte && !ackRdHdr) begin
        tenMatch_ff <= 1'b0;
      end
    end
  end

  // ****************************************
  // Link domain: SDA drive on SCL falling
  // ****************************************
  always_ff @(negedge sclClk or negedge linkRstN) begin
    if (!linkRstN) begin
      sdaAck_ff <= 1'b0;
      txPhase_ff <= 1'b0;
      txBit_ff <= '0;
    end else begin
      sdaAck_ff <= ackSlot & ackNext_ff;
      txPhase_ff <= readMode_ff & ~ackSlot & (txActive_ff | firstByte);
      txBit_ff <= 3'h7 - bitCnt_ff[2:0];
    end
  end

  // Ninth falling edge event; never reset mid-frame to avoid false edges
  always_ff @(negedge sclClk or negedge resetn) begin
    if (!resetn) begin
      nineTgl_ff <= 1'b0;
    end else if (linkRstN && bitCnt_ff == 4'h0 && !firstByte) begin
      nineTgl_ff <= ~nineTgl_ff;
    end
  end

  // Open-drain drive; transmit bit reads the held byte, stable while stretched
  assign sdaOut = 1'b0;
  assign sdaOe = sdaAck_ff | (txPhase_ff & txActive_ff & ~txHold_ff[txBit_ff]);

  // ****************************************
  // Crossing of link events
  // ****************************************
  wire logic byteEv;
  wire logic nineEv;
  assign byteEv = byteS2_ff ^ byteS3_ff;
  assign nineEv = nineS2_ff ^ nineS3_ff;

  // Toggle synchronisers
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      {byteS1_ff, byteS2_ff, byteS3_ff} <= 3'h0;
      {nineS1_ff, nineS2_ff, nineS3_ff} <= 3'h0;
    end else begin
      {byteS1_ff, byteS2_ff, byteS3_ff} <= {byteTgl_ff, byteS1_ff, byteS2_ff};
      {nineS1_ff, nineS2_ff, nineS3_ff} <= {nineTgl_ff, nineS1_ff, nineS2_ff};
    end
  end

  // Report is stable for nine SCL periods after its toggle
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      word_ff <= stretch_pkg::WORD_RST;
    end else if (byteEv) begin
      word_ff <= linkWord_ff;
    end
  end

  // ****************************************
  // Receive path and buffer state
  // ****************************************
  wire logic fifoReady;
  wire logic rxPush;
  wire logic rxFull;
  wire logic rxData;
  wire logic txData;
  assign rxData = word_ff.isData & ~word_ff.isRead;
  assign txData = linkWord_ff.isData & linkWord_ff.isRead;
  assign rxPush = byteEv & linkWord_ff.isData & ~linkWord_ff.isRead;
  assign rxFull = rdValid | rxPend_ff;
  // Direction comes from the crossed byte report, never from the SCL-domain flop itself
  assign bufferFull = word_ff.isRead ? txLoaded_ff : rxFull;

  stretch_fifo #(
    .WIDTH(stretch_pkg::BYTE_W),
    .DEPTH(DEPTH)
  ) u_rxFifo (
    .mclk(mclk),
    .resetn(resetn),
    .inValid(rxPend_ff),
    .inReady(fifoReady),
    .inData(rxPendData_ff),
    .outValid(rdValid),
    .outReady(rdReady),
    .outData(rdData)
  );

  // Pending byte waits here while the FIFO is full; SCL is held from the ninth fall meanwhile
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rxPend_ff <= 1'b0;
      rxPendData_ff <= '0;
    end else begin
      rxPend_ff <= rxPush | (rxPend_ff & ~fifoReady);
      if (rxPush) begin
        rxPendData_ff <= linkWord_ff.data;
      end
    end
  end

  // Transmit holding byte; a load wins over the shift-out clear
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      txHold_ff <= '0;
      txLoaded_ff <= 1'b0;
    end else begin
      if (txWr) begin
        txHold_ff <= txWrData;
      end
      txLoaded_ff <= txWr | (txLoaded_ff & ~(byteEv & txData));
    end
  end

  // ****************************************
  // Stretch decisions
  // ****************************************
  wire logic rxStretch;
  wire logic txStretch;
  wire logic hwClear;
  wire logic nxt_clockRelease;
  wire logic nxt_updAddr;
  wire logic nxt_uaStretch;
  wire logic nxt_fullHold;
  // Receive data bytes and acknowledged read bytes, read addresses included, consult buffer_full; write addresses never do
  assign rxStretch = rxData & stretchEnable & rxFull;
  assign txStretch = word_ff.isRead & word_ff.acked & ~txLoaded_ff;
  assign hwClear = nineEv & (rxStretch | txStretch);
  // Software set wins over the hardware clear in the same cycle
  assign nxt_clockRelease = ckpSet | (clockRelease_ff & ~hwClear);
  // Hardware set of the flag wins over an address write
  assign nxt_updAddr = (byteEv & linkWord_ff.setUa) | (updAddr_ff & ~addrWr);
  assign nxt_uaStretch = (nineEv & word_ff.setUa & updAddr_ff & ~addrWr) | (uaStretch_ff & ~addrWr);
  // Back-pressure starts only at the ninth fall; pulling SCL while it is high would cut a clock pulse
  assign nxt_fullHold = rxPend_ff & ~fifoReady & (nineEv | fullHold_ff);

  // Control flags
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      clockRelease_ff <= stretch_pkg::CKP_RST;
      updAddr_ff <= 1'b0;
      uaStretch_ff <= 1'b0;
      fullHold_ff <= 1'b0;
    end else begin
      clockRelease_ff <= nxt_clockRelease;
      updAddr_ff <= nxt_updAddr;
      uaStretch_ff <= nxt_uaStretch;
      fullHold_ff <= nxt_fullHold;
    end
  end

  // slave_address_reg
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      slaveAddr_ff <= stretch_pkg::ADDR_RST;
    end else if (addrWr) begin
      slaveAddr_ff <= addrWrData;
    end
  end

  // SCL hold straight from flops, so a set frees the line one edge later
  assign sclOut = 1'b0;
  assign sclOe = ~clockRelease_ff | uaStretch_ff | fullHold_ff;
  assign clockRelease = clockRelease_ff;
  assign updateAddress = updAddr_ff;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  sequence s_rxFullNine;
    nineEv && rxData && stretchEnable && rxFull && !ckpSet;
  endsequence

  sequence s_uaNine;
    nineEv && word_ff.setUa && updAddr_ff && !addrWr && !ckpSet;
  endsequence

  property p_rx_clear;
    s_rxFullNine |=> !clockRelease_ff ##0 sclOe;
  endproperty
  a_rx_clear: assert property (p_rx_clear) else $error("rx stretch missed");

  property p_rx_empty;
    nineEv && rxData && !rxFull && !txStretch |=> clockRelease_ff == $past(clockRelease_ff);
  endproperty
  a_rx_empty: assert property (p_rx_empty) else $error("empty buffer stretched");

  property p_sen_off;
    nineEv && rxData && !stretchEnable |=> $stable(clockRelease_ff);
  endproperty
  a_sen_off: assert property (p_sen_off) else $error("stretch without enable");

  property p_ckp_set;
    ckpSet |=> clockRelease_ff;
  endproperty
  a_ckp_set: assert property (p_ckp_set) else $error("clock_release set lost");

  property p_hold_low;
    !clockRelease_ff |-> sclOe;
  endproperty
  a_hold_low: assert property (p_hold_low) else $error("SCL not held");

  property p_release;
    !clockRelease_ff && ckpSet && !uaStretch_ff && !rxPend_ff && !rxPush |=> !sclOe;
  endproperty
  a_release: assert property (p_release) else $error("SCL not freed");

  property p_tx_clear;
    nineEv && txStretch && !ckpSet |=> !clockRelease_ff ##1 sclOe;
  endproperty
  a_tx_clear: assert property (p_tx_clear) else $error("tx stretch missed");

  property p_tx_loaded;
    nineEv && word_ff.isRead && txLoaded_ff && !rxStretch |=> $stable(clockRelease_ff);
  endproperty
  a_tx_loaded: assert property (p_tx_loaded) else $error("loaded tx stretched");

  property p_ua_stretch;
    s_uaNine |=> uaStretch_ff && sclOe && $stable(clockRelease_ff);
  endproperty
  a_ua_stretch: assert property (p_ua_stretch) else $error("address stretch wrong");

  property p_ua_set;
    byteEv && linkWord_ff.setUa |=> updAddr_ff [*2];
  endproperty
  a_ua_set: assert property (p_ua_set) else $error("flag not set");

  property p_ua_release;
    addrWr |=> !uaStretch_ff;
  endproperty
  a_ua_release: assert property (p_ua_release) else $error("address write kept stretch");

endmodule

/* rtl/stretch_pkg.sv */
// Constants and carrier types for the I2C slave clock-stretch block
package stretch_pkg;

  localparam logic [3:0] ACK_SLOT = 4'h8;      // Bit counter value of the ninth clock
  localparam logic [3:0] LAST_DATA_BIT = 4'h7; // Bit counter value of the eighth clock
  localparam logic [4:0] TEN_HDR = 5'h1E;      // High bits of a 10-bit address header
  localparam logic [9:0] ADDR_RST = 10'h000;   // slave_address_reg after reset
  localparam logic CKP_RST = 1'b1;             // clock_release after reset
  localparam logic [1:0] IDX_MAX = 2'h2;       // Byte index saturates here
  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 4;

  // Byte report passed from the SCL domain to the system domain
  typedef struct packed {
    logic [7:0] data;
    logic isData;
    logic setUa;
    logic isRead;
    logic acked;
  } linkWord_s;

  localparam linkWord_s WORD_RST = '0;

endpackage
